// >>> design/sdf_host_ctrl.sv
/*
 * Host controller of a four-channel sigma-delta filter unit: drives the
 * modulator bitstream, applies filter settings in a safe order, services
 * the filter reset pulse and clears flags, under APB control.
 * Assumes the filter unit outputs come from another clock domain and that
 * the unit takes its settings from these level outputs.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sdf_host_map.svh"
// Behaviour
// R1: Sinc3 at ratio 256 on all ones wraps instead of saturating.
// R2: At or above positive full scale the bitstream is all ones.
// R3: First enable of a data filter may give one spurious acknowledge.
// R4: Enable filter, wait latency plus 5 clocks, then enable interrupts.
// R5: A filter reset pulse may give one spurious acknowledge.
// R6: Clear the filter flags no sooner than 1.2 us after each reset pulse.
// R7: Clear flags while samples stay within N, else leave them set.
// R8: Each channel has over and under value flags, possibly spurious.
// R9: Comparator oversampling ratio is kept at 5 or more.
// R10: After ratio change wait latency plus 5 clocks before comparator ints.
// R11: Run-time comparator changes cause spurious events on all routes.
// R12: Comparator change: interrupts off, change, wait, interrupts on.
// R13: Comparator change: crossbar events off, change, wait, events on.
// R14: Run-time data filter changes cause spurious data-ready events.
// R15: Data change: filter off, change, wait latency plus 5, filter on.
// R16: Manchester decoding calibrates over 1024 transitions.
// R17: Manchester high and low pulses match within one system clock.
// R18: Clocked mode 0 is preferred over Manchester mode 2.
// R19: Filter flags stay set until cleared through the flag register.
module sdf_host_ctrl (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    // Modulator link
    output logic modulator_clock_input,
    output logic modulator_data_input,
    // Filter unit flags, asynchronous, and their registered clear
    input wire logic [3:0] data_ack_flag,
    input wire logic [3:0] over_value_flag,
    input wire logic [3:0] under_value_flag,
    input wire logic filter_reset_pulse,
    output logic [11:0] filter_flag_clear,
    // Filter unit settings
    output logic [1:0] input_mode,
    output logic data_filter_enable,
    output logic data_ack_int_enable,
    output logic [1:0] data_filter_type,
    output logic [7:0] data_oversampling_ratio,
    output logic [1:0] comparator_filter_type,
    output logic [4:0] comparator_oversampling_ratio,
    output logic [15:0] low_threshold,
    output logic [15:0] high_threshold,
    output logic over_value_int_enable,
    output logic under_value_int_enable,
    output logic comparator_xbar_enable
);
    sdf_host_pkg::host_state_s s_r;
    sdf_host_pkg::host_state_s s_nxt;
    logic bit_tick;
    logic settle_load;
    logic settle_done;
    logic guard_busy;
    logic guard_done;
    logic [15:0] settle_val;
    logic [12:0] rise;
    logic [3:0] svc_clr;
    logic [3:0] irq_ev;
    logic wr_en;

    function automatic logic addr_ok(input logic [11:0] a);
        addr_ok = (a == `OFF_CTRL) || (a == `OFF_DCFG) ||
                  (a == `OFF_CCFG) || (a == `OFF_THRESH) ||
                  (a == `OFF_PATTERN) || (a == `OFF_STATUS) ||
                  (a == `OFF_IRQ_STAT) || (a == `OFF_IRQ_MASK) ||
                  (a == `OFF_NSAMP) || (a == `OFF_CLKDIV) ||
                  (a == `OFF_FLAGCLR);
    endfunction

    function automatic logic [7:0] max8(input logic [7:0] a,
                                        input logic [7:0] b);
        max8 = (a > b) ? a : b;
    endfunction

    function automatic logic [31:0] rd_word(input logic [11:0] a,
            input sdf_host_pkg::host_state_s s);
        rd_word = 32'h0000_0000;
        unique case (a)
            `OFF_CTRL: rd_word = {25'h0, s.req_xbar, s.req_cint, s.req_dint,
                                  s.req_den, s.mode, 1'b0};
            `OFF_DCFG: rd_word = {8'h0, s.dlat, s.ddec, 6'h0, s.dtype};
            `OFF_CCFG: rd_word = {8'h0, s.clat, 9'h0, s.cdec, s.ctype};
            `OFF_THRESH: rd_word = {s.high, s.low};
            `OFF_PATTERN: rd_word = s.pattern;
            `OFF_STATUS: rd_word = {4'h0, s.sync2[11:0], s.samp_cnt,
                                    3'h0, s.state};
            `OFF_IRQ_STAT: rd_word = {28'h0, s.irq_stat};
            `OFF_IRQ_MASK: rd_word = {28'h0, s.irq_mask};
            `OFF_NSAMP: rd_word = {24'h0, s.nsamp};
            `OFF_CLKDIV: rd_word = {24'h0, s.clkdiv};
            default: rd_word = 32'h0000_0000;
        endcase
    endfunction

    modulator_bitstream u_bits (
        .pclk(pclk),
        .presetn(presetn),
        .half_div(s_r.clkdiv),
        .manchester(s_r.live_mode == `MODE_MANCHESTER),
        .pattern(s_r.pattern),
        .modulator_clock_input(modulator_clock_input),
        .modulator_data_input(modulator_data_input),
        .bit_tick(bit_tick)
    );

    // Wait counted in modulator clock periods, which this end makes itself.
    settle_timer u_settle (
        .pclk(pclk),
        .presetn(presetn),
        .load(settle_load),
        .load_val(settle_val),
        .tick(bit_tick),
        .busy(),
        .done(settle_done)
    );

    settle_timer u_guard (
        .pclk(pclk),
        .presetn(presetn),
        .load(rise[12]),
        .load_val(16'(`GUARD_CYC)),
        .tick(1'b1),
        .busy(guard_busy),
        .done(guard_done)
    );

    assign wr_en = psel && penable && pwrite;
    assign rise = s_r.sync2 & ~s_r.prev;
    assign settle_val = {7'h00, {1'b0, max8(s_r.dlat, s_r.clat)} +
                         `SETTLE_EXTRA}; // R4 R10
    assign settle_load = (s_r.state == sdf_host_pkg::ST_APPLY) ||
                         ((s_r.state == sdf_host_pkg::ST_SETTLE) &&
                          settle_done);

    always_comb begin
        logic [7:0] cnt_new;
        logic [11:0] sw_clr;
        cnt_new = s_r.samp_cnt;
        sw_clr = 12'h000;
        s_nxt = s_r;
        svc_clr = 4'h0;
        irq_ev = 4'h0;
        // The first stage feeds only the second.
        s_nxt.sync1 = {filter_reset_pulse, under_value_flag,
                       over_value_flag, data_ack_flag};
        s_nxt.sync2 = s_r.sync1;
        s_nxt.prev = s_r.sync2;
        if (psel && !penable && !pwrite) begin
            s_nxt.prdata = rd_word(paddr, s_r);
        end
        if (wr_en) begin
            unique case (paddr)
                `OFF_CTRL: begin
                    s_nxt.mode = pwdata[`CTRL_MODE_LO +: 2];
                    s_nxt.req_den = pwdata[`CTRL_DEN];
                    s_nxt.req_dint = pwdata[`CTRL_DINT];
                    s_nxt.req_cint = pwdata[`CTRL_CINT];
                    s_nxt.req_xbar = pwdata[`CTRL_XBAR];
                    if (pwdata[`CTRL_GO] &&
                        s_r.state == sdf_host_pkg::ST_IDLE) begin
                        s_nxt.state = sdf_host_pkg::ST_QUIET;
                    end
                end
                `OFF_DCFG: begin
                    s_nxt.dtype = pwdata[1:0];
                    s_nxt.ddec = pwdata[15:8];
                    s_nxt.dlat = pwdata[23:16];
                end
                `OFF_CCFG: begin
                    s_nxt.ctype = pwdata[1:0];
                    s_nxt.cdec = pwdata[6:2];
                    s_nxt.clat = pwdata[23:16];
                end
                `OFF_THRESH: begin
                    s_nxt.low = pwdata[15:0];
                    s_nxt.high = pwdata[31:16];
                end
                `OFF_PATTERN: s_nxt.pattern = pwdata;
                `OFF_IRQ_MASK: s_nxt.irq_mask = pwdata[3:0];
                `OFF_NSAMP: s_nxt.nsamp = pwdata[7:0];
                `OFF_CLKDIV: s_nxt.clkdiv = pwdata[7:0];
                `OFF_FLAGCLR: sw_clr = pwdata[11:0];
                default: s_nxt.prdata = s_r.prdata;
            endcase
        end
        unique case (s_r.state)
            sdf_host_pkg::ST_IDLE: s_nxt.state = s_nxt.state;
            sdf_host_pkg::ST_QUIET: begin
                s_nxt.live_dint = 1'b0; // R4
                s_nxt.live_cint = 1'b0; // R12
                s_nxt.live_xbar = 1'b0; // R13
                s_nxt.live_den = 1'b0; // R15
                s_nxt.state = sdf_host_pkg::ST_APPLY;
            end
            sdf_host_pkg::ST_APPLY: begin
                s_nxt.live_mode = s_r.mode; // R18
                s_nxt.live_dtype = s_r.dtype;
                s_nxt.live_ddec = s_r.ddec;
                s_nxt.live_ctype = s_r.ctype;
                s_nxt.live_cdec = (s_r.cdec < `CDEC_MIN) ? `CDEC_MIN
                                                         : s_r.cdec; // R9
                s_nxt.live_low = s_r.low;
                s_nxt.live_high = s_r.high;
                s_nxt.state = sdf_host_pkg::ST_SETTLE;
            end
            sdf_host_pkg::ST_SETTLE: begin
                if (settle_done) begin
                    s_nxt.live_den = s_r.req_den; // R15
                    s_nxt.live_cint = s_r.req_cint; // R10 R12
                    s_nxt.live_xbar = s_r.req_xbar; // R13
                    s_nxt.state = sdf_host_pkg::ST_ARMWAIT;
                end
            end
            sdf_host_pkg::ST_ARMWAIT: begin
                if (settle_done) begin
                    s_nxt.live_dint = s_r.req_dint; // R4
                    irq_ev[`IRQ_SEQ_DONE] = 1'b1;
                    s_nxt.state = sdf_host_pkg::ST_IDLE;
                end
            end
        endcase
        // Acknowledges inside the guard window are possibly spurious.
        if (rise[12]) begin
            s_nxt.samp_cnt = 8'h00;
        end else if ((rise[3:0] != 4'h0) && !guard_busy) begin
            cnt_new = (s_r.samp_cnt == 8'hff) ? 8'hff
                                              : s_r.samp_cnt + 8'h01;
            s_nxt.samp_cnt = cnt_new;
            if (cnt_new <= s_r.nsamp) begin
                svc_clr = rise[3:0]; // R7
            end else begin
                irq_ev[`IRQ_LIMIT] = 1'b1;
            end
        end
        if (guard_done) begin
            svc_clr = 4'hf; // R6
        end
        irq_ev[`IRQ_CMP] = |rise[11:4];
        irq_ev[`IRQ_DACK] = |rise[3:0];
        s_nxt.clr = sw_clr | {8'h00, svc_clr};
        // A new event wins over a write-one clear in the same cycle.
        s_nxt.irq_stat = s_r.irq_stat | irq_ev;
        if (wr_en && paddr == `OFF_IRQ_STAT) begin
            s_nxt.irq_stat = (s_r.irq_stat & ~pwdata[3:0]) | irq_ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.state <= sdf_host_pkg::ST_IDLE;
            s_r.mode <= `MODE_CLOCKED;
            s_r.live_mode <= `MODE_CLOCKED;
            s_r.ddec <= `RST_DDEC;
            s_r.live_ddec <= `RST_DDEC;
            s_r.cdec <= `RST_CDEC;
            s_r.live_cdec <= `RST_CDEC;
            s_r.dlat <= `RST_LAT;
            s_r.clat <= `RST_LAT;
            s_r.nsamp <= `RST_NSAMP;
            s_r.clkdiv <= `RST_CLKDIV;
            s_r.pattern <= `RST_PATTERN;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok(paddr);
    assign irq = |(s_r.irq_stat & s_r.irq_mask);
    assign filter_flag_clear = s_r.clr;
    assign input_mode = s_r.live_mode;
    assign data_filter_enable = s_r.live_den;
    assign data_ack_int_enable = s_r.live_dint;
    assign data_filter_type = s_r.live_dtype;
    assign data_oversampling_ratio = s_r.live_ddec;
    assign comparator_filter_type = s_r.live_ctype;
    assign comparator_oversampling_ratio = s_r.live_cdec;
    assign low_threshold = s_r.live_low;
    assign high_threshold = s_r.live_high;
    assign over_value_int_enable = s_r.live_cint;
    assign under_value_int_enable = s_r.live_cint;
    assign comparator_xbar_enable = s_r.live_xbar;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_comparator_oversampling_ratio_floor: assert property ( // R9
        s_r.live_cdec >= `CDEC_MIN)
        else $error("Comparator ratio below floor.");
    a_cmp_quiet: assert property ( // R10 R12
        (s_r.state == sdf_host_pkg::ST_APPLY ||
         s_r.state == sdf_host_pkg::ST_SETTLE) |->
            !s_r.live_cint && !s_r.live_dint)
        else $error("Interrupt enabled during settle.");
    a_xbar_quiet: assert property ( // R13
        $rose(s_r.live_xbar) |->
            $past(s_r.state) == sdf_host_pkg::ST_SETTLE && $past(settle_done))
        else $error("Crossbar events enabled before settle.");
    a_filter_off: assert property ( // R15
        s_r.state == sdf_host_pkg::ST_QUIET |=>
            !s_r.live_den [*2] ##1 !s_r.live_den)
        else $error("Data filter on while settings change.");
    a_dint_last: assert property ( // R4
        $rose(s_r.live_dint) |->
            $past(s_r.state) == sdf_host_pkg::ST_ARMWAIT && s_r.live_den)
        else $error("Acknowledge interrupt enabled too early.");
    a_guard_hold: assert property ( // R6
        guard_busy |-> svc_clr == 4'h0)
        else $error("Flags cleared inside guard window.");
    a_guard_clear: assert property ( // R6
        guard_done |=> s_r.clr[3:0] == 4'hf)
        else $error("Flags not cleared after guard window.");
    a_limit_hold: assert property ( // R7
        (svc_clr != 4'h0) && !guard_done |-> s_nxt.samp_cnt <= s_r.nsamp)
        else $error("Flag cleared past sample limit.");
    a_mode_apply: assert property ( // R18
        $changed(s_r.live_mode) |->
            $past(s_r.state) == sdf_host_pkg::ST_APPLY)
        else $error("Input mode changed outside apply.");
endmodule
`default_nettype wire

// >>> design/sdf_host_map.svh
/*
 * Register offsets, field positions, reset values and timing counts of
 * the sigma-delta filter host controller.
 * Assumes a 250 MHz pclk and APB byte addressing with aligned words.
 */
`ifndef SDF_HOST_MAP_SVH
`define SDF_HOST_MAP_SVH

`define OFF_CTRL 12'h000
`define OFF_DCFG 12'h004
`define OFF_CCFG 12'h008
`define OFF_THRESH 12'h00c
`define OFF_PATTERN 12'h010
`define OFF_STATUS 12'h014
`define OFF_IRQ_STAT 12'h018
`define OFF_IRQ_MASK 12'h01c
`define OFF_NSAMP 12'h020
`define OFF_CLKDIV 12'h024
`define OFF_FLAGCLR 12'h028

`define CTRL_GO 0
`define CTRL_MODE_LO 1
`define CTRL_DEN 3
`define CTRL_DINT 4
`define CTRL_CINT 5
`define CTRL_XBAR 6

`define IRQ_SEQ_DONE 0
`define IRQ_LIMIT 1
`define IRQ_CMP 2
`define IRQ_DACK 3

`define MODE_CLOCKED 2'h0
`define MODE_MANCHESTER 2'h2
`define RST_CDEC 5'h05
`define RST_DDEC 8'hff
`define RST_LAT 8'h10
`define RST_NSAMP 8'h04
`define RST_CLKDIV 8'h0f
`define RST_PATTERN 32'haaaa_5555

`define CDEC_MIN 5'h05
`define SETTLE_EXTRA 9'h005
`define GUARD_NS 1200
`define PCLK_MHZ 250
`define GUARD_CYC ((`GUARD_NS * `PCLK_MHZ + 999) / 1000)

`endif

// >>> design/sdf_host_pkg.sv
/*
 * Types of the sigma-delta filter host controller.
 * Assumes the constants of sdf_host_map.svh.
 */
package sdf_host_pkg;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_QUIET = 5'h02,
        ST_APPLY = 5'h04,
        ST_SETTLE = 5'h08,
        ST_ARMWAIT = 5'h10
    } seq_state_e;

    typedef struct packed {
        seq_state_e state;
        logic [31:0] prdata;
        logic [1:0] mode;
        logic req_den;
        logic req_dint;
        logic req_cint;
        logic req_xbar;
        logic [1:0] dtype;
        logic [7:0] ddec;
        logic [7:0] dlat;
        logic [1:0] ctype;
        logic [4:0] cdec;
        logic [7:0] clat;
        logic [15:0] low;
        logic [15:0] high;
        logic [31:0] pattern;
        logic [7:0] nsamp;
        logic [7:0] clkdiv;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic live_den;
        logic live_dint;
        logic live_cint;
        logic live_xbar;
        logic [1:0] live_mode;
        logic [1:0] live_dtype;
        logic [7:0] live_ddec;
        logic [1:0] live_ctype;
        logic [4:0] live_cdec;
        logic [15:0] live_low;
        logic [15:0] live_high;
        logic [12:0] sync1;
        logic [12:0] sync2;
        logic [12:0] prev;
        logic [7:0] samp_cnt;
        logic [11:0] clr;
    } host_state_s;

    typedef struct packed {
        logic [7:0] div;
        logic clk;
        logic data;
        logic [4:0] pos;
        logic tick;
    } bits_state_s;

    typedef struct packed {
        logic [15:0] cnt;
        logic busy;
        logic done;
    } timer_state_s;

endpackage

// >>> design/settle_timer.sv
/*
 * Down counter that waits a loaded number of ticks and pulses done.
 * Assumes load and tick come from logic on pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module settle_timer (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic load,
    input wire logic [15:0] load_val,
    input wire logic tick,
    // Status
    output logic busy,
    output logic done
);
    sdf_host_pkg::timer_state_s s_r;
    sdf_host_pkg::timer_state_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (load) begin
            // A zero load would wrap and wait 65536 ticks, so it waits one tick instead.
            s_nxt.cnt = (load_val == 16'h0000) ? 16'h0001 : load_val;
            s_nxt.busy = 1'b1;
        end else if (s_r.busy && tick) begin
            if (s_r.cnt == 16'h0001) begin
                s_nxt.busy = 1'b0;
                s_nxt.done = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt - 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy = s_r.busy;
    assign done = s_r.done;

    a_done_ends_busy: assert property (@(posedge pclk) disable iff (!presetn)
        s_r.done |-> !s_r.busy && $past(s_r.busy))
        else $error("Timer done without a preceding wait.");
endmodule
`default_nettype wire

// >>> design/modulator_bitstream.sv
/*
 * Modulator end: derives the modulator clock from pclk and shifts out a
 * pattern word, either clocked (mode 0) or Manchester coded.
 * Assumes the filter unit samples data on the rising modulator clock.
 */
`timescale 1ns/1ps
`default_nettype none
module modulator_bitstream (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Settings
    input wire logic [7:0] half_div,
    input wire logic manchester,
    input wire logic [31:0] pattern,
    // Link
    output logic modulator_clock_input,
    output logic modulator_data_input,
    output logic bit_tick
);
    sdf_host_pkg::bits_state_s s_r;
    sdf_host_pkg::bits_state_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (s_r.div == 8'h00) begin
            // Both halves reload the same count, so high and low match.
            s_nxt.div = half_div; // R17
            s_nxt.clk = ~s_r.clk;
            if (s_r.clk) begin
                s_nxt.pos = s_r.pos + 5'h01;
                s_nxt.data = manchester ? ~pattern[s_nxt.pos]
                                        : pattern[s_nxt.pos];
            end else begin
                s_nxt.tick = 1'b1;
                if (manchester) begin
                    s_nxt.data = pattern[s_r.pos];
                end
            end
        end else begin
            s_nxt.div = s_r.div - 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign modulator_clock_input = s_r.clk;
    assign modulator_data_input = s_r.data;
    assign bit_tick = s_r.tick;

    a_half_equal: assert property (@(posedge pclk) disable iff (!presetn) // R17
        $changed(s_r.clk) && $stable(half_div) |-> s_r.div == half_div)
        else $error("Modulator half period cut short.");
endmodule
`default_nettype wire

// >>> dv/filter_unit_model.sv
/* Behavioural four-channel filter unit: raises data acknowledge flags
   after a fixed number of modulator clock rises, and comparator flags
   on request.
   Assumes the host drives its settings and clear pulses on pclk. */
`timescale 1ns/1ps
`default_nettype none
module filter_unit_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Host side
    input wire logic modulator_clock_input,
    input wire logic data_filter_enable,
    input wire logic [11:0] filter_flag_clear,
    input wire logic cmp_evt,
    // Flags
    output logic [3:0] data_ack_flag,
    output logic [3:0] over_value_flag,
    output logic [3:0] under_value_flag
);
    logic mclk_d;
    logic [2:0] rises;
    logic ack_evt;
    // A short fixed decimation keeps runs brief; real ratios are far longer.
    assign ack_evt = modulator_clock_input && !mclk_d && (rises == 3'h7);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mclk_d <= 1'b0;
            rises <= 3'h0;
            data_ack_flag <= 4'h0;
            over_value_flag <= 4'h0;
            under_value_flag <= 4'h0;
        end else begin
            mclk_d <= modulator_clock_input;
            if (!data_filter_enable)
                rises <= 3'h0;
            else if (modulator_clock_input && !mclk_d)
                rises <= rises + 3'h1;
            // Set wins over clear, so an event is never lost.
            data_ack_flag <= (data_ack_flag & ~filter_flag_clear[3:0])
                | {4{ack_evt && data_filter_enable}};
            over_value_flag <= (over_value_flag & ~filter_flag_clear[7:4])
                | {4{cmp_evt}};
            under_value_flag <= (under_value_flag & ~filter_flag_clear[11:8])
                | {4{cmp_evt}};
        end
    end
endmodule
`default_nettype wire

// >>> dv/sdf_host_ctrl_tb.sv
/* Self-checking bench of the sigma-delta filter host controller.
   Assumes the register map of sdf_host_map.svh and the unit model. */
`timescale 1ns/1ps
`default_nettype none
`include "sdf_host_map.svh"
module sdf_host_ctrl_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic filter_reset_pulse = 1'b0;
    logic cmp_evt = 1'b0;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, irq, rerr, modulator_clock_input;
    logic data_filter_enable, data_ack_int_enable, over_value_int_enable;
    logic comparator_xbar_enable;
    logic [11:0] filter_flag_clear;
    logic [3:0] data_ack_flag, over_value_flag, under_value_flag;
    logic [1:0] data_filter_type, input_mode;
    logic [4:0] comparator_oversampling_ratio;
    logic [7:0] data_oversampling_ratio;
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;

    sdf_host_ctrl dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .irq, .modulator_clock_input,
        .modulator_data_input(), .data_ack_flag, .over_value_flag,
        .under_value_flag, .filter_reset_pulse, .filter_flag_clear,
        .input_mode, .data_filter_enable, .data_ack_int_enable,
        .data_filter_type, .data_oversampling_ratio,
        .comparator_filter_type(), .comparator_oversampling_ratio,
        .low_threshold(), .high_threshold(), .over_value_int_enable,
        .under_value_int_enable(), .comparator_xbar_enable);
    filter_unit_model unit (.pclk, .presetn, .modulator_clock_input,
        .data_filter_enable, .filter_flag_clear, .cmp_evt, .data_ack_flag,
        .over_value_flag, .under_value_flag);

    always #2 pclk = ~pclk;
    // The whole run needs under a thousand cycles; the ceiling is generous.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (error_cnt == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic s_reset_and_map();
        chk("ddec", 32'hff, {24'h0, data_oversampling_ratio});
        chk("cdec", 32'h05, {27'h0, comparator_oversampling_ratio});
        chk("den", 32'h0, {31'h0, data_filter_enable});
        apb(1'b0, 12'h0fc, 32'h0);
        chk("pslverr", 32'h1, {31'h0, rerr});
    endtask

    task automatic s_first_enable();
        int n;
        apb(1'b1, `OFF_CLKDIV, 32'h1);
        apb(1'b1, `OFF_DCFG, 32'h0002_1003);
        apb(1'b1, `OFF_CCFG, 32'h0002_0009);
        apb(1'b1, `OFF_IRQ_MASK, 32'h1);
        apb(1'b1, `OFF_CTRL, 32'h79);
        do @(posedge pclk); while (data_filter_enable !== 1'b1);
        chk("dint", 32'h0, {31'h0, data_ack_int_enable});
        chk("cint", 32'h1, {31'h0, over_value_int_enable});
        chk("cdec", 32'h05, {27'h0, comparator_oversampling_ratio});
        chk("dtype", 32'h3, {30'h0, data_filter_type});
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (data_ack_int_enable !== 1'b1);
        chk("arm wait", 32'h1, {31'h0, n >= 24});
        do @(posedge pclk); while (irq !== 1'b1);
        apb(1'b0, `OFF_IRQ_STAT, 32'h0);
        chk("seq done", 32'h1, {31'h0, rdat[0]});
        apb(1'b1, `OFF_IRQ_STAT, 32'h1);
        apb(1'b0, `OFF_IRQ_STAT, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
    endtask

    task automatic s_reconfig();
        apb(1'b1, `OFF_CCFG, 32'h0002_0019);
        apb(1'b1, `OFF_CTRL, 32'h7d);
        do @(posedge pclk); while (comparator_oversampling_ratio !== 5'h06);
        chk("mode", 32'h2, {30'h0, input_mode});
        chk("cint", 32'h0, {31'h0, over_value_int_enable});
        chk("xbar", 32'h0, {31'h0, comparator_xbar_enable});
        chk("den", 32'h0, {31'h0, data_filter_enable});
        do @(posedge pclk); while (data_ack_int_enable !== 1'b1);
    endtask

    task automatic s_cmp_flags();
        @(posedge pclk);
        cmp_evt <= 1'b1;
        @(posedge pclk);
        cmp_evt <= 1'b0;
        repeat (8) @(posedge pclk);
        chk("over", 32'hf, {28'h0, over_value_flag});
        apb(1'b0, `OFF_IRQ_STAT, 32'h0);
        chk("cmp stat", 32'h1, {31'h0, rdat[2]});
        apb(1'b1, `OFF_FLAGCLR, 32'h0000_0ff0);
        repeat (2) @(posedge pclk);
        chk("under", 32'h0, {28'h0, under_value_flag});
    endtask

    task automatic s_filter_reset();
        int n;
        apb(1'b1, `OFF_NSAMP, 32'h1);
        apb(1'b1, `OFF_IRQ_STAT, 32'hf);
        @(posedge pclk);
        filter_reset_pulse <= 1'b1;
        repeat (4) @(posedge pclk);
        filter_reset_pulse <= 1'b0;
        n = 4;
        do begin
            @(posedge pclk);
            n++;
        end while (filter_flag_clear[0] !== 1'b1);
        chk("guard", 32'h1, {31'h0, n >= 300});
        repeat (200) @(posedge pclk);
        apb(1'b0, `OFF_IRQ_STAT, 32'h0);
        chk("limit", 32'h1, {31'h0, rdat[1]});
        chk("ack kept", 32'hf, {28'h0, data_ack_flag});
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        s_reset_and_map();
        s_first_enable();
        s_reconfig();
        s_cmp_flags();
        s_filter_reset();
        complete_run();
    end
endmodule
`default_nettype wire
